// File: logic/pps_pkg.sv
// What this block does
// - lookup, matrix, histogram and min/max touch only RGBA groups; others pass.
// - post-filter lookup enable held in a flop, clear at reset; clear means pass.
// - separate post-matrix lookup enable, clear at reset, same lookup behaviour.
// - each RGBA vector is multiplied by the 4x4 colour matrix after the post-filter lookup.
// - each matrix result is scaled by its signed scale, then signed bias added.
// - histogram enable clear means no counter changes and groups pass on.
// - nonzero width: index = round(clamp(c,0,1)*(min(width,256)-1)); pixel unchanged.
// - per group, bump R/L, G, B, A counters at their indices if format has them.
// - counter overflow wraps silently, no error raised.
// - histogram discard off forwards groups; on drops every RGBA group after counting.
// - groups dropped by histogram discard skip the min/max update.
// - dropped groups give no output at all; statistics state is kept.
// - min/max enable clear leaves stored extremes unchanged, groups pass.
// - red minimum replaced only when incoming red is strictly smaller.
// - red maximum replaced only when incoming red is strictly larger.
// - green, blue, alpha extremes update the same way when format has them.
// - extremes stored with at least the colour component range.
// - min/max discard on drops every RGBA group right after the update.
// - statistics state updates whether or not groups are dropped, except min/max for groups dropped by histogram discard.
package pps_pkg;
  // ----------------------------------------
  // component format
  // ----------------------------------------
  localparam int NUM_COMP = 4;
  localparam int COMP_W = 16;
  localparam int FRAC_W = 12;
  localparam int ACC_W = 2 * COMP_W + 2;
  localparam logic signed [COMP_W-1:0] ONE = 16'sh1000;
  localparam logic signed [COMP_W-1:0] COMP_MAX = 16'sh7FFF;
  localparam logic signed [COMP_W-1:0] COMP_MIN = 16'sh8000;
  localparam logic [FRAC_W:0] ROUND_HALF = 13'h0800;

  // ----------------------------------------
  // histogram table
  // ----------------------------------------
  localparam int HIST_DEPTH = 256;
  localparam int HIST_IDX_W = 8;
  localparam int HIST_CNT_W = 16;

  typedef logic signed [COMP_W-1:0] pps_comp_t;
  typedef pps_comp_t [NUM_COMP-1:0] pps_group_t;
  typedef pps_group_t [NUM_COMP-1:0] pps_matrix_t;

  typedef enum logic {
    PPS_CLR_IDLE = 1'b0,
    PPS_CLR_RUN = 1'b1
  } pps_clr_state_t;
endpackage : pps_pkg

// File: logic/pps_hist_if.sv
interface pps_hist_if #(
  parameter int IDX_W = pps_pkg::HIST_IDX_W,
  parameter int CNT_W = pps_pkg::HIST_CNT_W
);
  logic [pps_pkg::NUM_COMP-1:0] inc_en;
  logic [pps_pkg::NUM_COMP-1:0][IDX_W-1:0] inc_idx;
  logic clr_req;
  logic clr_busy;
  logic [IDX_W-1:0] rd_idx;
  logic [pps_pkg::NUM_COMP-1:0][CNT_W-1:0] rd_data;

  modport pipe (
    output inc_en, inc_idx, clr_req, rd_idx,
    input clr_busy, rd_data
  );
  modport mem (
    input inc_en, inc_idx, clr_req, rd_idx,
    output clr_busy, rd_data
  );
endinterface : pps_hist_if

// File: logic/pps_hist_mem.sv
module pps_hist_mem #(
  parameter int DEPTH = pps_pkg::HIST_DEPTH,
  parameter int IDX_W = pps_pkg::HIST_IDX_W,
  parameter int CNT_W = pps_pkg::HIST_CNT_W
) (
  input wire logic core_clk,
  input wire logic reset,
  pps_hist_if.mem hif
);
  localparam logic [IDX_W-1:0] LAST = IDX_W'(DEPTH - 1);

  pps_pkg::pps_clr_state_t clr_state;
  logic [IDX_W-1:0] clr_ptr;
  logic busy;

  // ----------------------------------------
  // clear sweep, also run after reset
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clr_state <= pps_pkg::PPS_CLR_RUN;
      clr_ptr <= '0;
    end else begin
      case (clr_state)
        pps_pkg::PPS_CLR_IDLE: begin
          clr_ptr <= '0;
          if (hif.clr_req) begin
            clr_state <= pps_pkg::PPS_CLR_RUN;
          end
        end
        pps_pkg::PPS_CLR_RUN: begin
          clr_ptr <= clr_ptr + 1'b1;
          if (clr_ptr == LAST) begin
            clr_state <= pps_pkg::PPS_CLR_IDLE;
          end
        end
        default: begin
          clr_state <= pps_pkg::PPS_CLR_IDLE;
        end
      endcase
    end
  end

  assign busy = (clr_state == pps_pkg::PPS_CLR_RUN);
  assign hif.clr_busy = busy;

  // ----------------------------------------
  // one counter bank per component
  // ----------------------------------------
  for (genvar b = 0; b < pps_pkg::NUM_COMP; b++) begin : g_bank
    logic [CNT_W-1:0] cells [DEPTH];
    logic pend_en;
    logic [IDX_W-1:0] pend_idx;
    logic [CNT_W-1:0] pend_val;
    logic [CNT_W-1:0] base;
    logic [CNT_W-1:0] rd_q;

    // newest count, forwarded from the pending write
    always_comb begin
      if (pend_en && pend_idx == hif.inc_idx[b]) begin
        base = pend_val;
      end else begin
        base = cells[hif.inc_idx[b]];
      end
    end

    // read-modify-write, increments ignored while clearing
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        pend_en <= 1'b0;
        pend_idx <= '0;
        pend_val <= '0;
      end else begin
        pend_en <= hif.inc_en[b] && !busy;
        pend_idx <= hif.inc_idx[b];
        pend_val <= base + 1'b1; // wraps on overflow
      end
    end

    // storage, clear sweep wins over a pending write
    always_ff @(posedge core_clk) begin
      if (busy) begin
        cells[clr_ptr] <= '0;
      end else if (pend_en) begin
        cells[pend_idx] <= pend_val;
      end
    end

    // registered software read
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        rd_q <= '0;
      end else begin
        rd_q <= cells[hif.rd_idx];
      end
    end

    assign hif.rd_data[b] = rd_q;
  end
endmodule : pps_hist_mem

// File: logic/pps_pipe.sv
module pps_pipe #(
  parameter int HIST_DEPTH = pps_pkg::HIST_DEPTH,
  parameter int IDX_W = pps_pkg::HIST_IDX_W,
  parameter int CNT_W = pps_pkg::HIST_CNT_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_rgba,
  input wire pps_pkg::pps_group_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_rgba,
  output pps_pkg::pps_group_t out_data,
  input wire logic post_filter_lut_enable,
  output pps_pkg::pps_group_t pf_lut_addr,
  input wire pps_pkg::pps_group_t pf_lut_data,
  input wire pps_pkg::pps_matrix_t color_matrix,
  input wire pps_pkg::pps_group_t post_scale,
  input wire pps_pkg::pps_group_t post_bias,
  input wire logic post_matrix_lut_enable,
  output pps_pkg::pps_group_t pm_lut_addr,
  input wire pps_pkg::pps_group_t pm_lut_data,
  input wire logic hist_enable,
  input wire logic hist_sink,
  input wire logic [IDX_W:0] hist_width,
  input wire logic [pps_pkg::NUM_COMP-1:0] hist_fmt,
  input wire logic hist_clear,
  output logic hist_clear_busy,
  input wire logic [IDX_W-1:0] hist_rd_idx,
  output logic [pps_pkg::NUM_COMP-1:0][CNT_W-1:0] hist_rd_data,
  input wire logic minmax_enable,
  input wire logic minmax_sink,
  input wire logic [pps_pkg::NUM_COMP-1:0] minmax_fmt,
  input wire logic minmax_reset,
  output pps_pkg::pps_group_t min_value,
  output pps_pkg::pps_group_t max_value
);
  // shorthand for the package widths
  localparam int NC = pps_pkg::NUM_COMP;
  localparam int FW = pps_pkg::FRAC_W;
  localparam int AW = pps_pkg::ACC_W;
  localparam logic [IDX_W:0] DEPTH_W = (IDX_W + 1)'(HIST_DEPTH);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // saturate a wide accumulator to one component
  function automatic pps_pkg::pps_comp_t sat(input logic signed [AW-1:0] v);
    if (v > pps_pkg::COMP_MAX) begin
      return pps_pkg::COMP_MAX;
    end else if (v < pps_pkg::COMP_MIN) begin
      return pps_pkg::COMP_MIN;
    end else begin
      return v[pps_pkg::COMP_W-1:0];
    end
  endfunction : sat

  // clamp to [0,1], scale by width-1, round half up
  function automatic logic [IDX_W-1:0] hist_index(
    input pps_pkg::pps_comp_t c,
    input logic [IDX_W:0] wm1
  );
    logic [FW:0] cl;
    logic [FW+IDX_W+1:0] prod;
    if (c < 0) begin
      cl = '0;
    end else if (c > pps_pkg::ONE) begin
      cl = pps_pkg::ONE[FW:0];
    end else begin
      cl = c[FW:0];
    end
    prod = cl * wm1 + pps_pkg::ROUND_HALF;
    return prod[FW +: IDX_W];
  endfunction : hist_index

  // ----------------------------------------
  // held enables
  // ----------------------------------------
  // registered copies of the enable inputs
  logic pf_en;
  logic pm_en;
  logic hist_on;
  logic mm_on;

  // post-filter lookup enable, clear at reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pf_en <= 1'b0;
    end else begin
      pf_en <= post_filter_lut_enable;
    end
  end

  // post-matrix lookup enable, clear at reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pm_en <= 1'b0;
    end else begin
      pm_en <= post_matrix_lut_enable;
    end
  end

  // histogram counting enable
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hist_on <= 1'b0;
    end else begin
      hist_on <= hist_enable;
    end
  end

  // min/max tracking enable
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mm_on <= 1'b0;
    end else begin
      mm_on <= minmax_enable;
    end
  end

  // ----------------------------------------
  // pipeline stages 0..4, output stage 5
  // ----------------------------------------
  // stage flags and data, index 5 is the output stage
  logic [5:0] vld;
  logic [5:0] rgba;
  logic [5:0] next_rgba;
  pps_pkg::pps_group_t [5:0] dat;
  pps_pkg::pps_group_t [5:0] next_dat;
  logic [5:0] next_vld;
  pps_pkg::pps_group_t mat_out;
  pps_pkg::pps_group_t scaled;
  logic signed [AW-1:0] mat_acc;
  logic signed [AW-1:0] sc_acc;
  logic adv;
  logic drop_h;
  logic drop_m;
  logic hist_fire;
  logic mm_fire;

  // whole pipe stalls when the output holds a group
  assign adv = !vld[5] || out_ready;
  assign in_ready = adv;
  assign out_valid = vld[5];
  assign out_rgba = rgba[5];
  assign out_data = dat[5];
  assign pf_lut_addr = dat[0];
  assign pm_lut_addr = dat[3];

  // colour matrix product
  always_comb begin
    mat_out = '0;
    for (int i = 0; i < NC; i++) begin
      mat_acc = '0;
      for (int j = 0; j < NC; j++) begin
        mat_acc = mat_acc + color_matrix[i][j] * dat[1][j];
      end
      mat_out[i] = sat(mat_acc >>> FW);
    end
  end

  // per-component scale then bias
  always_comb begin
    scaled = '0;
    for (int i = 0; i < NC; i++) begin
      sc_acc = dat[2][i] * post_scale[i];
      sc_acc = (sc_acc >>> FW) + post_bias[i];
      scaled[i] = sat(sc_acc);
    end
  end

  // stage transforms, non-RGBA groups pass untouched
  always_comb begin
    next_dat[0] = in_data;
    next_dat[1] = (pf_en && rgba[0]) ? pf_lut_data : dat[0];
    next_dat[2] = rgba[1] ? mat_out : dat[1];
    next_dat[3] = rgba[2] ? scaled : dat[2];
    next_dat[4] = (pm_en && rgba[3]) ? pm_lut_data : dat[3];
    next_dat[5] = dat[4];
    next_vld = {vld[4] && !(drop_h || drop_m),
      vld[3:0], in_valid};
    next_rgba = {rgba[4:0], in_rgba};
  end

  // valid flags, a dropped group leaves a bubble
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      vld <= '0;
    end else if (adv) begin
      vld <= next_vld;
    end
  end

  // group type flags travel with the data
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rgba <= '0;
    end else if (adv) begin
      rgba <= next_rgba;
    end
  end

  // stage data
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dat <= '0;
    end else if (adv) begin
      dat <= next_dat;
    end
  end

  // ----------------------------------------
  // statistics on stage 4
  // ----------------------------------------
  logic [IDX_W:0] width_eff;
  logic [IDX_W:0] wm1;

  // table width clamped to the depth, minus one for scaling
  assign width_eff = (hist_width > DEPTH_W) ? DEPTH_W : hist_width;
  assign wm1 = width_eff - 1'b1;

  // discard decisions, histogram first
  assign drop_h = rgba[4] && hist_on && hist_sink;
  assign drop_m = rgba[4] && mm_on && minmax_sink && !drop_h;
  assign hist_fire = adv && vld[4] && rgba[4] && hist_on
    && (width_eff != '0);
  assign mm_fire = adv && vld[4] && rgba[4] && mm_on && !drop_h;

  // link to the counter table
  pps_hist_if #(.IDX_W(IDX_W), .CNT_W(CNT_W)) hif ();

  // one increment per present component
  for (genvar c = 0; c < NC; c++) begin : g_hidx
    assign hif.inc_en[c] = hist_fire && hist_fmt[c];
    assign hif.inc_idx[c] = hist_index(dat[4][c], wm1);
  end

  // clear and read requests pass straight through
  assign hif.clr_req = hist_clear;
  assign hif.rd_idx = hist_rd_idx;
  assign hist_clear_busy = hif.clr_busy;
  assign hist_rd_data = hif.rd_data;

  // counter banks and clear sweep
  pps_hist_mem #(
    .DEPTH(HIST_DEPTH),
    .IDX_W(IDX_W),
    .CNT_W(CNT_W)
  ) u_hist_mem (
    .core_clk(core_clk),
    .reset(reset),
    .hif(hif)
  );

  // ----------------------------------------
  // minimum and maximum tracking
  // ----------------------------------------
  // working copies of the extremes
  pps_pkg::pps_group_t min_base;
  pps_pkg::pps_group_t max_base;
  pps_pkg::pps_group_t next_min;
  pps_pkg::pps_group_t next_max;

  // reset request first, so an update in the same cycle still lands
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      min_base[c] = minmax_reset ? pps_pkg::COMP_MAX : min_value[c];
      max_base[c] = minmax_reset ? pps_pkg::COMP_MIN : max_value[c];
      next_min[c] = min_base[c];
      next_max[c] = max_base[c];
      if (mm_fire && minmax_fmt[c]) begin
        if (dat[4][c] < min_base[c]) begin
          next_min[c] = dat[4][c];
        end
        if (dat[4][c] > max_base[c]) begin
          next_max[c] = dat[4][c];
        end
      end
    end
  end

  // stored minimum, full component range, kept across drops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      min_value <= {NC{pps_pkg::COMP_MAX}};
    end else begin
      min_value <= next_min;
    end
  end

  // stored maximum, full component range, kept across drops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      max_value <= {NC{pps_pkg::COMP_MIN}};
    end else begin
      max_value <= next_max;
    end
  end
endmodule : pps_pipe

// File: tb/pps_lut_model.sv
module pps_lut_model #(
  parameter logic [15:0] OFS = 16'h0010
) (
  input wire pps_pkg::pps_group_t addr,
  output pps_pkg::pps_group_t data
);
  // table answers in the same cycle, offset marks each entry
  always_comb begin
    for (int i = 0; i < pps_pkg::NUM_COMP; i++) begin
      data[i] = addr[i] + OFS;
    end
  end
endmodule : pps_lut_model

// File: tb/pps_pipe_checker.sv
module pps_pipe_checker #(
  parameter int IDX_W = pps_pkg::HIST_IDX_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic in_rgba,
  input wire pps_pkg::pps_group_t in_data,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_rgba,
  input wire pps_pkg::pps_group_t out_data,
  input wire logic hist_enable,
  input wire logic hist_sink,
  input wire logic [IDX_W:0] hist_width,
  input wire logic hist_clear,
  input wire logic hist_clear_busy,
  input wire logic minmax_enable,
  input wire logic minmax_sink,
  input wire logic minmax_reset,
  input wire pps_pkg::pps_group_t min_value,
  input wire pps_pkg::pps_group_t max_value
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----
  // sequences
  // ----
  sequence s_take(bit r);
    in_valid && in_ready && in_rgba == r;
  endsequence
  sequence s_mm_idle;
    (!minmax_enable && !minmax_reset) ##1 !minmax_reset;
  endsequence
  // ----
  // properties
  // ----
  a_ready_rule: assert property (in_ready == (!out_valid || out_ready))
    else $error("ready does not follow stall");
  a_stall_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_rgba))
    else $error("output moved while stalled");
  a_other_pass: assert property (s_take(0) ##0 out_ready[*6] |=>
    out_valid && !out_rgba && out_data == $past(in_data, 6))
    else $error("non rgba group altered");
  a_hist_drop: assert property (s_take(1) ##0 (out_ready && hist_enable
    && hist_sink && hist_width != 0 && !hist_clear_busy)[*6] |=> !out_valid)
    else $error("histogram sink let a group out");
  a_mm_drop: assert property (s_take(1) ##0 (out_ready && minmax_enable
    && minmax_sink)[*6] |=> !out_valid)
    else $error("minmax sink let a group out");
  a_min_down: assert property (!minmax_reset |=>
    $signed(min_value[0]) <= $signed($past(min_value[0])))
    else $error("minimum grew");
  a_max_up: assert property (!minmax_reset |=>
    $signed(max_value[0]) >= $signed($past(max_value[0])))
    else $error("maximum shrank");
  a_mm_off_hold: assert property (s_mm_idle |=>
    $stable(min_value) && $stable(max_value))
    else $error("extremes moved while off");
  a_clear_start: assert property (hist_clear && !hist_clear_busy |=>
    hist_clear_busy[*8])
    else $error("clear sweep did not start");
endmodule : pps_pipe_checker

bind pps_pipe pps_pipe_checker #(.IDX_W(IDX_W)) pps_pipe_checker_inst (.*);

// File: tb/pps_pipe_tb_top.sv
module pps_pipe_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, reset, in_valid, in_ready, in_rgba, out_valid, out_ready;
  logic out_rgba, post_filter_lut_enable, post_matrix_lut_enable;
  logic hist_enable, hist_sink, hist_clear, hist_clear_busy;
  logic minmax_enable, minmax_sink, minmax_reset;
  logic [8:0] hist_width;
  logic [3:0] hist_fmt, minmax_fmt;
  logic [7:0] hist_rd_idx;
  logic [63:0] hist_rd_data;
  pps_pkg::pps_group_t in_data, out_data, pf_lut_addr, pf_lut_data;
  pps_pkg::pps_group_t pm_lut_addr, pm_lut_data, post_scale, post_bias;
  pps_pkg::pps_group_t min_value, max_value;
  pps_pkg::pps_matrix_t color_matrix;
  pps_pkg::pps_group_t exp_q[$], got_q[$];
  int fails, total_checks, n;

  pps_pipe pps_pipe_inst (.*);
  pps_lut_model #(.OFS(16'h0010)) pf_lut_model_inst (.addr(pf_lut_addr),
    .data(pf_lut_data));
  pps_lut_model #(.OFS(16'h0020)) pm_lut_model_inst (.addr(pm_lut_addr),
    .data(pm_lut_data));

  // ----
  // clock, watchdog, output capture
  // ----
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    end_of_test();
  end
  always @(posedge core_clk) begin
    if (!reset && out_valid && out_ready) got_q.push_back(out_data);
  end

  // ----
  // tasks
  // ----
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, seen, want);
    end
  endtask : check

  function automatic pps_pkg::pps_group_t model(pps_pkg::pps_group_t g);
    int acc;
    pps_pkg::pps_group_t r;
    for (int i = 0; i < 4; i++) begin
      acc = 0;
      for (int j = 0; j < 4; j++) begin
        acc += color_matrix[i][j] * (g[j] + (post_filter_lut_enable ? 16 : 0));
      end
      acc = (((acc >>> 12) * post_scale[i]) >>> 12) + post_bias[i];
      acc = acc + (post_matrix_lut_enable ? 32 : 0);
      r[i] = acc[15:0];
    end
    return r;
  endfunction : model

  task automatic send(input logic r, input pps_pkg::pps_group_t g);
    int k;
    in_valid = 1;
    in_rgba = r;
    in_data = g;
    k = 0;
    @(posedge core_clk);
    while (!in_ready && k < 100) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 100) fails++;
    @(negedge core_clk);
    if (!r) exp_q.push_back(g);
    else if (!(hist_enable && hist_sink) && !(minmax_enable && minmax_sink))
      exp_q.push_back(model(g));
  endtask : send

  task automatic flush(input string name);
    in_valid = 0;
    repeat (12) @(negedge core_clk);
    check(got_q.size(), exp_q.size());
    while (got_q.size() > 0 && exp_q.size() > 0)
      check(got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
    $display("test %s done", name);
  endtask : flush

  task automatic rd(input logic [7:0] idx, input logic [63:0] want);
    hist_rd_idx = idx;
    repeat (2) @(negedge core_clk);
    check(hist_rd_data, want);
  endtask : rd

  task automatic set_matrix(input bit rev);
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        color_matrix[i][j] = ((rev ? 3 - i : i) == j) ? pps_pkg::ONE : '0;
      end
    end
    repeat (2) @(negedge core_clk);
  endtask : set_matrix

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ----
  // test sequence
  // ----
  initial begin
    {fails, total_checks, n} = '0;
    {reset, out_ready} = 2'h3;
    {in_valid, in_rgba, hist_clear, minmax_reset} = '0;
    {post_filter_lut_enable, post_matrix_lut_enable} = '0;
    {hist_enable, hist_sink, minmax_enable, minmax_sink} = '0;
    {in_data, post_bias, hist_rd_idx} = '0;
    {hist_fmt, minmax_fmt} = 8'hFF;
    hist_width = 9'h100;
    post_scale = {4{pps_pkg::ONE}};
    set_matrix(0);
    repeat (8) @(negedge core_clk);
    reset = 0;
    check(min_value, {4{16'h7FFF}});
    check(max_value, {4{16'h8000}});
    while (hist_clear_busy !== 1'b0 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    check(hist_clear_busy, 1'b0);
    send(1, {16'h0400, 16'h0300, 16'h0200, 16'h0100});
    send(0, {16'h0123, 16'hF456, 16'h0789, 16'h0ABC});
    flush("bypass");
    {post_filter_lut_enable, post_matrix_lut_enable, out_ready} = 3'h6;
    repeat (2) @(negedge core_clk);
    fork
      for (int k = 0; k < 8; k++) send(k[0], {4{16'(256 + k)}});
      begin
        repeat (15) @(negedge core_clk);
        out_ready <= 1;
      end
    join
    flush("lookup");
    {post_filter_lut_enable, post_matrix_lut_enable} = '0;
    post_scale = {4{16'h2000}};
    post_bias = {16'hFF00, 16'h0100, 16'h0080, 16'h0040};
    set_matrix(1);
    send(1, {16'h0400, 16'h0300, 16'hFE00, 16'h0100});
    send(1, {16'h1000, 16'h0800, 16'h0010, 16'hF800});
    flush("matrix");
    post_scale = {4{pps_pkg::ONE}};
    post_bias = '0;
    set_matrix(0);
    rd(8'h10, '0);
    {hist_enable, hist_width} = {1'b1, 9'h000};
    repeat (2) @(negedge core_clk);
    send(1, {16'h2000, 16'hF000, 16'h1000, 16'h0800});
    flush("hist width zero");
    rd(8'h80, '0);
    hist_width = 9'h100;
    send(1, {16'h2000, 16'hF000, 16'h1000, 16'h0800});
    send(1, {16'h2000, 16'hF000, 16'h1000, 16'h0800});
    flush("hist count");
    rd(8'h80, 64'h0000_0000_0000_0002);
    rd(8'hFF, 64'h0002_0000_0002_0000);
    rd(8'h00, 64'h0000_0002_0000_0000);
    hist_fmt = 4'h1;
    send(1, {16'h2000, 16'hF000, 16'h1000, 16'h0800});
    flush("hist format");
    rd(8'h80, 64'h0000_0000_0000_0003);
    rd(8'hFF, 64'h0002_0000_0002_0000);
    {hist_fmt, hist_clear, n} = {4'hF, 1'b1, 32'h0};
    @(negedge core_clk);
    hist_clear = 0;
    while (hist_clear_busy === 1'b1 && n < 400) begin
      n++;
      @(negedge core_clk);
    end
    check(n, 256);
    rd(8'hFF, '0);
    {hist_enable, minmax_reset, minmax_fmt} = {2'h1, 4'h7};
    @(negedge core_clk);
    {minmax_reset, minmax_enable} = 2'h1;
    repeat (2) @(negedge core_clk);
    send(1, {16'h0400, 16'h0300, 16'h0200, 16'h0100});
    send(1, {16'h0010, 16'h0300, 16'h0500, 16'hF000});
    flush("minmax");
    check(min_value, {16'h7FFF, 16'h0300, 16'h0200, 16'hF000});
    check(max_value, {16'h8000, 16'h0300, 16'h0500, 16'h0100});
    minmax_enable = 0;
    repeat (2) @(negedge core_clk);
    send(1, {4{16'hE000}});
    flush("minmax off");
    check(min_value, {16'h7FFF, 16'h0300, 16'h0200, 16'hF000});
    {minmax_enable, hist_enable, hist_sink} = 3'h7;
    repeat (2) @(negedge core_clk);
    send(1, {4{16'hE000}});
    send(0, {4{16'h0123}});
    flush("hist sink");
    check(min_value, {16'h7FFF, 16'h0300, 16'h0200, 16'hF000});
    rd(8'h00, {4{16'h0001}});
    {hist_sink, minmax_sink} = 2'h1;
    send(1, {4{16'hD000}});
    send(0, {4{16'h0456}});
    flush("minmax sink");
    check(min_value, {16'h7FFF, {3{16'hD000}}});
    rd(8'h00, {4{16'h0002}});
    end_of_test();
  end
endmodule : pps_pipe_tb_top
